// ==== design/bank_if.sv ====
// Purpose: Carrier between the register decoder and one enable bank
// Assumes: Single clock domain
// Notes: Write strobe is a one-cycle pulse
`timescale 1ns/1ps
interface bank_if #(parameter int CHANNELS = 8);
    logic wr;
    logic [CHANNELS-1:0] wdata;
    logic [CHANNELS-1:0] en;
    modport ctrl (output wr, output wdata, input en);
    modport bank (input wr, input wdata, output en);
endinterface

// ==== design/enable_bank.sv ====
// Purpose: Per-channel span extension enables of one converter bank
// Assumes: Writes arrive already decoded
// Notes: All enables clear on reset
`timescale 1ns/1ps
module enable_bank
    import ovr_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Decoder side
    bank_if.bank port
);
    typedef struct packed {
        logic [CHANNELS-1:0] en;
    } bank_state_t;

    bank_state_t state_q;
    bank_state_t state_d;
    logic [CHANNELS-1:0] next_en;

    // One enable per channel; clear means the plain range
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        assign next_en[i] = port.wr ? port.wdata[i] : state_q.en[i]; // [RULE9]
    end

    always_comb begin
        state_d = state_q;
        state_d.en = next_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0; // [RULE9]
        end else begin
            state_q <= state_d;
        end
    end

    assign port.en = state_q.en;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hold_no_write: assert property (!port.wr |=> $stable(state_q.en)) // [RULE9]
        else $error("Enable changed without a write");
    a_take_write: assert property (port.wr |=> state_q.en == $past(port.wdata)) // [RULE9]
        else $error("Enable did not take written value");
endmodule

// ==== design/overrange_config_regs.sv ====
// Purpose: APB register pair enabling span extension per channel
// Assumes: APB slave, one clock, asynchronous active-low reset
// Notes: Answers every access with pready one cycle into access phase
//
// How it works
// RULE1: Word bit 15: 0 read, 1 write
// RULE2: Word bits 14..9 select the register
// RULE3: Bank B at 0xB, resets to 0x1600
// RULE4: Bit 8 reserved, always reads zero
// RULE5: Bank A bits 7..4 extend channels 7..4
// RULE6: Bank A bits 3..0 extend channels 3..0
// RULE7: Bank B bits 7..4 extend channels 7..4
// RULE8: Bank B bits 3..1 extend channels 3..1
// RULE9: Enables read/write, reset zero, zero means plain
// RULE10: Bank A at 0xA, resets to 0x1400
// RULE11: Bank B bit 0 extends channel 0
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module overrange_config_regs
    import ovr_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Span extension enables, one bit per channel
    output logic [CHANNELS-1:0] extend_span_a,
    output logic [CHANNELS-1:0] extend_span_b
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] cmd_result;
        logic cmd_miss;
    } apb_state_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CMD = 2'b01,
        SEL_A = 2'b11,
        SEL_B = 2'b10
    } target_t;

    apb_state_t state_q;
    apb_state_t state_d;

    bank_if #(.CHANNELS(CHANNELS)) bank_a ();
    bank_if #(.CHANNELS(CHANNELS)) bank_b ();

    enable_bank #(.CHANNELS(CHANNELS)) u_bank_a (
        .pclk(pclk),
        .presetn(presetn),
        .port(bank_a.bank)
    );

    enable_bank #(.CHANNELS(CHANNELS)) u_bank_b (
        .pclk(pclk),
        .presetn(presetn),
        .port(bank_b.bank)
    );

    // Full register word: direction bit reads 0, own index, reserved 0
    function automatic logic [15:0] reg_word(input logic [5:0] idx,
                                             input logic [CHANNELS-1:0] en);
        logic [15:0] w;
        w = '0;
        w[SEL_HI:SEL_LO] = idx;
        w[RSVD_BIT] = 1'b0; // [RULE4]
        w[CHANNELS-1:0] = en;
        return w;
    endfunction

    logic access;
    logic setup_done;
    logic commit;
    target_t target;
    logic [15:0] word;
    logic word_is_write;
    logic [5:0] word_sel;
    logic [15:0] word_a;
    logic [15:0] word_b;

    assign access = psel && penable;
    // First access cycle computes the answer; second completes it
    assign setup_done = access && !state_q.pready;
    assign commit = access && state_q.pready;
    assign word = pwdata[15:0];
    assign word_is_write = word[DIR_BIT]; // [RULE1]
    assign word_sel = word[SEL_HI:SEL_LO]; // [RULE2]
    assign word_a = reg_word(IDX_BANK_A, bank_a.en); // [RULE10]
    assign word_b = reg_word(IDX_BANK_B, bank_b.en); // [RULE3]

    // Address decode; misaligned addresses count as unmapped
    always_comb begin
        unique case (paddr)
            ADDR_CMD: target = SEL_CMD;
            ADDR_BANK_A: target = SEL_A; // [RULE10]
            ADDR_BANK_B: target = SEL_B; // [RULE3]
            default: target = SEL_NONE;
        endcase
    end

    // Bank write strobes, taken only at the completing edge
    always_comb begin
        bank_a.wr = 1'b0;
        bank_b.wr = 1'b0;
        bank_a.wdata = pwdata[CHANNELS-1:0];
        bank_b.wdata = pwdata[CHANNELS-1:0];
        if (commit && pwrite) begin
            unique case (target)
                SEL_A: bank_a.wr = pstrb[0]; // [RULE5] [RULE6]
                SEL_B: bank_b.wr = pstrb[0]; // [RULE7] [RULE8] [RULE11]
                SEL_CMD: begin
                    if (pstrb[1:0] == 2'b11 && word_is_write) begin // [RULE1]
                        bank_a.wr = (word_sel == IDX_BANK_A); // [RULE2]
                        bank_b.wr = (word_sel == IDX_BANK_B); // [RULE2]
                    end
                end
                SEL_NONE: begin
                    bank_a.wr = 1'b0;
                    bank_b.wr = 1'b0;
                end
            endcase
        end
    end

    // Answer path and command-word result
    always_comb begin
        state_d = state_q;
        state_d.pready = 1'b0;
        state_d.pslverr = 1'b0;
        if (setup_done) begin
            state_d.pready = 1'b1;
            state_d.prdata = '0;
            unique case (target)
                SEL_A: state_d.prdata[15:0] = pwrite ? 16'h0000 : word_a;
                SEL_B: state_d.prdata[15:0] = pwrite ? 16'h0000 : word_b;
                SEL_CMD: begin
                    if (!pwrite) begin
                        state_d.prdata[15:0] = state_q.cmd_result;
                        state_d.prdata[CMD_MISS_BIT] = state_q.cmd_miss;
                    end
                end
                SEL_NONE: state_d.pslverr = 1'b1;
            endcase
        end
        // Command word: select by field, direction by top bit
        if (commit && pwrite && target == SEL_CMD && pstrb[1:0] == 2'b11) begin
            if (word_sel == IDX_BANK_A) begin // [RULE2]
                state_d.cmd_miss = 1'b0;
                state_d.cmd_result = word_is_write ?
                    reg_word(IDX_BANK_A, word[CHANNELS-1:0]) : word_a; // [RULE1]
            end else if (word_sel == IDX_BANK_B) begin // [RULE2]
                state_d.cmd_miss = 1'b0;
                state_d.cmd_result = word_is_write ?
                    reg_word(IDX_BANK_B, word[CHANNELS-1:0]) : word_b; // [RULE1]
            end else begin
                state_d.cmd_miss = 1'b1;
                state_d.cmd_result = RESET_CMD_RESULT;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.prdata <= '0;
            state_q.pready <= 1'b0;
            state_q.pslverr <= 1'b0;
            state_q.cmd_result <= RESET_CMD_RESULT;
            state_q.cmd_miss <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    // Enables come straight from the bank flip-flops
    assign extend_span_a = bank_a.en; // [RULE5] [RULE6]
    assign extend_span_b = bank_b.en; // [RULE7] [RULE8] [RULE11]

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic cmd_commit;
    assign cmd_commit = commit && pwrite && target == SEL_CMD && pstrb[1:0] == 2'b11;

    sequence s_read_setup(target_t t);
        setup_done && !pwrite && target == t;
    endsequence

    a_dir_read_only: assert property ( // [RULE1]
        cmd_commit && !pwdata[DIR_BIT]
        |=> $stable(extend_span_a) && $stable(extend_span_b))
        else $error("Read command word changed an enable");

    a_dir_write_a: assert property ( // [RULE1]
        cmd_commit && pwdata[DIR_BIT] && pwdata[SEL_HI:SEL_LO] == IDX_BANK_A
        |=> extend_span_a == $past(pwdata[CHANNELS-1:0]))
        else $error("Write command word did not reach bank A");

    a_sel_miss: assert property ( // [RULE2]
        cmd_commit && pwdata[SEL_HI:SEL_LO] != IDX_BANK_A
        && pwdata[SEL_HI:SEL_LO] != IDX_BANK_B
        |=> state_q.cmd_miss && $stable(extend_span_a) && $stable(extend_span_b))
        else $error("Unknown select field was not refused");

    a_bank_b_word: assert property ( // [RULE3]
        s_read_setup(SEL_B)
        |=> pready && prdata == {16'h0000, RESET_BANK_B[15:8], extend_span_b})
        else $error("Bank B read word wrong");

    a_bank_a_word: assert property ( // [RULE10]
        s_read_setup(SEL_A)
        |=> pready && prdata == {16'h0000, RESET_BANK_A[15:8], extend_span_a})
        else $error("Bank A read word wrong");

    a_rsvd_zero: assert property ( // [RULE4]
        pready && !pslverr && access && !pwrite
        && (target == SEL_A || target == SEL_B)
        |-> !prdata[RSVD_BIT])
        else $error("Reserved bit read as one");

    a_bank_a_direct: assert property ( // [RULE5] [RULE6]
        commit && pwrite && target == SEL_A && pstrb[0]
        |=> extend_span_a == $past(pwdata[CHANNELS-1:0]) && $stable(extend_span_b))
        else $error("Direct write to bank A lost");

    a_bank_b_direct: assert property ( // [RULE7] [RULE8] [RULE11]
        commit && pwrite && target == SEL_B && pstrb[0]
        |=> extend_span_b == $past(pwdata[CHANNELS-1:0]) && $stable(extend_span_a))
        else $error("Direct write to bank B lost");

    a_reset_clear: assert property ( // [RULE9]
        $rose(presetn) |-> extend_span_a == RESET_ENABLES
        && extend_span_b == RESET_ENABLES)
        else $error("Enables not clear after reset");

    a_answer_time: assert property ( // [RULE1]
        setup_done |=> pready ##1 !pready)
        else $error("Answer not one cycle into access phase");

    a_dir_write_b: assert property ( // [RULE1]
        cmd_commit && pwdata[DIR_BIT] && pwdata[SEL_HI:SEL_LO] == IDX_BANK_B
        |=> extend_span_b == $past(pwdata[CHANNELS-1:0]) && $stable(extend_span_a))
        else $error("Write command word did not reach bank B");

    a_cmd_result_a: assert property ( // [RULE2]
        cmd_commit && pwdata[DIR_BIT] && pwdata[SEL_HI:SEL_LO] == IDX_BANK_A
        |=> state_q.cmd_result == {1'b0, IDX_BANK_A, 1'b0, $past(pwdata[CHANNELS-1:0])}
            && !state_q.cmd_miss)
        else $error("Command result for bank A wrong");

    a_cmd_read_word: assert property ( // [RULE1]
        cmd_commit && !pwdata[DIR_BIT] && pwdata[SEL_HI:SEL_LO] == IDX_BANK_A
        |=> state_q.cmd_result == {RESET_BANK_A[15:8], extend_span_a} && !state_q.cmd_miss)
        else $error("Read command did not capture bank A");

    a_cmd_miss_flag: assert property ( // [RULE2]
        cmd_commit && (pwdata[SEL_HI:SEL_LO] == IDX_BANK_A
        || pwdata[SEL_HI:SEL_LO] == IDX_BANK_B)
        |=> !state_q.cmd_miss)
        else $error("Miss flag set on a known select");

    a_cmd_strb_refused: assert property ( // [RULE1]
        commit && pwrite && target == SEL_CMD && pstrb[1:0] != 2'b11
        |=> $stable(extend_span_a) && $stable(extend_span_b)
            && $stable(state_q.cmd_result))
        else $error("Partial command write took effect");

    a_direct_strb_off: assert property ( // [RULE9]
        commit && pwrite && (target == SEL_A || target == SEL_B) && !pstrb[0]
        |=> $stable(extend_span_a) && $stable(extend_span_b))
        else $error("Write without strobe changed an enable");

    a_unmapped_err: assert property ( // [RULE2]
        setup_done && target == SEL_NONE
        |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped address not refused");

    a_unmapped_keep: assert property ( // [RULE2]
        commit && target == SEL_NONE
        |=> $stable(extend_span_a) && $stable(extend_span_b))
        else $error("Unmapped access changed an enable");

    a_write_answer: assert property ( // [RULE9]
        setup_done && pwrite && target != SEL_NONE
        |=> pready && !pslverr && prdata == 32'h0000_0000)
        else $error("Write answer not clean");

    a_cmd_result_read: assert property ( // [RULE2]
        s_read_setup(SEL_CMD)
        |=> pready && !pslverr
            && prdata == {15'h0000, state_q.cmd_miss, state_q.cmd_result})
        else $error("Command result read wrong");

    a_read_no_write: assert property ( // [RULE1]
        commit && !pwrite |=> $stable(extend_span_a) && $stable(extend_span_b))
        else $error("Read access changed an enable");

    a_idle_no_write: assert property ( // [RULE9]
        !commit |=> $stable(extend_span_a) && $stable(extend_span_b))
        else $error("Enable changed outside a completing write");

    a_ready_in_access: assert property ( // [RULE1]
        pready |-> psel && penable)
        else $error("Answer outside access phase");

    a_err_with_ready: assert property ( // [RULE2]
        pslverr |-> pready)
        else $error("Error flag without answer");

    // Each channel enable follows its own data bit only
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan_chk
        a_chan_a_bit: assert property ( // [RULE5] [RULE6]
            commit && pwrite && target == SEL_A && pstrb[0]
            |=> extend_span_a[i] == $past(pwdata[i]))
            else $error("Bank A channel enable missed its bit");

        a_chan_b_bit: assert property ( // [RULE7] [RULE8] [RULE11]
            commit && pwrite && target == SEL_B && pstrb[0]
            |=> extend_span_b[i] == $past(pwdata[i]))
            else $error("Bank B channel enable missed its bit");
    end

    c_read_a: cover property (s_read_setup(SEL_A) ##1 pready);
    c_cmd_write_b: cover property (
        cmd_commit && pwdata[DIR_BIT] && pwdata[SEL_HI:SEL_LO] == IDX_BANK_B);
    c_unmapped: cover property (pready && pslverr);
    c_cmd_read: cover property (cmd_commit && !pwdata[DIR_BIT]);
    c_cmd_refused: cover property (commit && pwrite && target == SEL_CMD && pstrb[1:0] != 2'b11);
endmodule

// ==== design/ovr_pkg.sv ====
// Purpose: Constants for the over-range enable register pair
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indexes sit at byte address four times the index
package ovr_pkg;
    // Register indexes and their byte addresses
    localparam logic [5:0] IDX_CMD = 6'h00;
    localparam logic [5:0] IDX_BANK_A = 6'h0a;
    localparam logic [5:0] IDX_BANK_B = 6'h0b;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CMD = {IDX_CMD, 2'b00};
    localparam logic [7:0] ADDR_BANK_A = {IDX_BANK_A, 2'b00};
    localparam logic [7:0] ADDR_BANK_B = {IDX_BANK_B, 2'b00};
    // Register word layout
    localparam int DIR_BIT = 15;
    localparam int SEL_HI = 14;
    localparam int SEL_LO = 9;
    localparam int RSVD_BIT = 8;
    localparam int CH_HI = 7;
    localparam int CMD_MISS_BIT = 16;
    // Values after reset
    localparam logic [15:0] RESET_BANK_A = 16'h1400;
    localparam logic [15:0] RESET_BANK_B = 16'h1600;
    localparam logic [7:0] RESET_ENABLES = 8'h00;
    localparam logic [15:0] RESET_CMD_RESULT = 16'h0000;
endpackage

// ==== tb/apb_host.sv ====
// Purpose: Host controller model issuing APB register transfers
// Assumes: One clock; signals change just after a rising edge
// Notes: Released address and data lines show inverted last values
`timescale 1ns/1ps
module apb_host
    import ovr_pkg::*;
(
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // Command word: direction, register select, enables
    function automatic logic [31:0] cmd_word(input logic wr, input logic [5:0] sel,
                                             input logic [7:0] en);
        return {16'h0000, wr, sel, 1'b0, en};
    endfunction

    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== tb/tb_overrange_config_regs.sv ====
// Purpose: Self-checking bench for the over-range enable registers
// Assumes: Answers are compared in order of issue
// Notes: Second reset in mid-run rechecks reset values
`timescale 1ns/1ps
module tb_overrange_config_regs;
    import ovr_pkg::*;
    typedef struct packed {logic [31:0] rdata; logic err;} note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] extend_span_a, extend_span_b, en_a, en_b;
    note_t notes[$];
    note_t nt;
    int n_errors = 0;
    int n_compared = 0;

    apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
    overrange_config_regs #(.CHANNELS(8)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extend_span_a(extend_span_a), .extend_span_b(extend_span_b));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("Errors %0d, compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Enables are sampled mid-cycle, after the write edge has landed
    task automatic chk_en(input logic [7:0] a, input logic [7:0] b);
        @(negedge pclk);
        n_compared++;
        if ({extend_span_a, extend_span_b} !== {a, b}) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time,
                     {extend_span_a, extend_span_b}, {a, b});
        end
    endtask

    function automatic logic [31:0] rdv(input logic [5:0] idx, input logic [7:0] en);
        return {16'h0000, 1'b0, idx, 1'b0, en};
    endfunction

    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] exp, input logic err);
        notes.push_back('{exp, err});
        u_host.xfer(wr, a, d, s);
    endtask

    // Answer monitor: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (presetn === 1'b1 && psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                cmp({pslverr, prdata}, 33'h1_ffff_ffff);
            end else begin
                nt = notes.pop_front();
                cmp({pslverr, prdata}, {nt.err, nt.rdata});
            end
        end
    end

    initial begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        end_sim();
    end

    initial begin
        presetn = 1'b0;
        void'($urandom(89243));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int pass = 0; pass < 2; pass++) begin
            chk_en(8'h00, 8'h00);
            acc(1'b0, ADDR_BANK_A, 32'h0, 4'h0, rdv(IDX_BANK_A, 8'h00), 1'b0);
            acc(1'b0, ADDR_BANK_B, 32'h0, 4'h0, rdv(IDX_BANK_B, 8'h00), 1'b0);
            // Walking one, then random, with reserved bit set on both banks and direction bit set on bank A only
            for (int i = 0; i < 12; i++) begin
                en_a = (i < 8) ? 8'h01 << i : 8'($urandom);
                en_b = (i < 8) ? 8'h80 >> i : 8'($urandom);
                acc(1'b1, ADDR_BANK_A, {16'h0, 8'h81, en_a}, 4'hf, 32'h0, 1'b0);
                acc(1'b1, ADDR_BANK_B, {16'h0, 8'h01, en_b}, 4'h1, 32'h0, 1'b0);
                chk_en(en_a, en_b);
                acc(1'b0, ADDR_BANK_A, 32'h0, 4'h0, rdv(IDX_BANK_A, en_a), 1'b0);
                acc(1'b0, ADDR_BANK_B, 32'h0, 4'h0, rdv(IDX_BANK_B, en_b), 1'b0);
            end
            acc(1'b1, ADDR_BANK_A, 32'h0, 4'he, 32'h0, 1'b0);
            chk_en(en_a, en_b);
            acc(1'b1, ADDR_BANK_A, 32'h0, 4'h1, 32'h0, 1'b0);
            en_a = 8'h00;
            chk_en(en_a, en_b);
            acc(1'b0, 8'h14, 32'h0, 4'h0, 32'h0, 1'b1);
            acc(1'b1, 8'h29, 32'hff, 4'hf, 32'h0, 1'b1);
            chk_en(en_a, en_b);
            // Command word path: write, read and unknown select
            en_b = 8'ha5;
            acc(1'b1, ADDR_CMD, u_host.cmd_word(1'b1, IDX_BANK_B, en_b),
                4'h3, 32'h0, 1'b0);
            en_a = 8'($urandom);
            acc(1'b1, ADDR_CMD, u_host.cmd_word(1'b1, IDX_BANK_A, en_a),
                4'h3, 32'h0, 1'b0);
            chk_en(en_a, en_b);
            // Partial strobes on a command word are ignored; a read command word changes no enable
            acc(1'b1, ADDR_CMD, u_host.cmd_word(1'b1, IDX_BANK_B, ~en_b), 4'h1,
                32'h0, 1'b0);
            acc(1'b1, ADDR_CMD, u_host.cmd_word(1'b0, IDX_BANK_A, 8'hff), 4'h3,
                32'h0, 1'b0);
            chk_en(en_a, en_b);
            acc(1'b0, ADDR_CMD, 32'h0, 4'h0, rdv(IDX_BANK_A, en_a), 1'b0);
            acc(1'b1, ADDR_CMD, u_host.cmd_word(1'b0, 6'h05, 8'h00), 4'h3,
                32'h0, 1'b0);
            acc(1'b0, ADDR_CMD, 32'h0, 4'h0, 32'h0001_0000, 1'b0);
            @(posedge pclk);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
        end
        repeat (2) @(posedge pclk);
        end_sim();
    end
endmodule
